//--- hw/iod_pkg.sv
// Constants and types for the indexed-offset instruction decode block.
// Assumes one clock with four clock cycles (Q1..Q4) per instruction cycle.
package iod_pkg;
    // Operand field layout of the 16-bit instruction word
    localparam int OFFSET_LSB = 0;
    localparam int ACCESS_BIT = 8;
    localparam int DEST_BIT = 9;
    localparam int BITPOS_LSB = 9;
    // Opcode prefixes
    localparam logic [5:0] ADD_PREFIX = 6'h09;
    localparam logic [3:0] BSET_PREFIX = 4'h8;
    localparam logic [6:0] FILL_PREFIX = 7'h34;
    // Addressing
    localparam logic [7:0] IDX_MAX_OFFSET = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    // Data values
    localparam logic [7:0] FILL_VALUE = 8'hff;
    localparam logic DEST_ACC = 1'b0;
    // Status flag positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    // Reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic EXT_RESET = 1'b0;
    localparam logic [15:0] NOP_WORD = 16'h0000;

    typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_BSET, OP_FILL} iod_op_t;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} iod_phase_t;
endpackage : iod_pkg

//--- hw/iod_dec_if.sv
// Carrier between the execute core and the instruction decoder.
// Assumes the core owns the word and the pointers, the decoder answers combinationally.
`timescale 1ns/1ps
interface iod_dec_if;
    logic clk;
    logic rst;
    logic [15:0] word;
    logic ext_en;
    logic [11:0] frame_ptr;
    logic [3:0] bank;
    iod_pkg::iod_op_t op;
    logic dest_f;
    logic [2:0] bitpos;
    logic indexed;
    logic [11:0] eff_addr;

    modport dec (input clk, input rst, input word, input ext_en, input frame_ptr, input bank,
                 output op, output dest_f, output bitpos, output indexed, output eff_addr);
    modport core (output clk, output rst, output word, output ext_en, output frame_ptr, output bank,
                  input op, input dest_f, input bitpos, input indexed, input eff_addr);
endinterface : iod_dec_if

//--- hw/iod_decode.sv
// Opcode classification and effective address formation.
// Assumes the word, pointer and bank inputs stay stable while the core samples the answer.
`timescale 1ns/1ps
module iod_decode (
    iod_dec_if.dec dif
);
    function automatic iod_pkg::iod_op_t classify(input logic [15:0] w);
        if (w[15:10] == iod_pkg::ADD_PREFIX)
            return iod_pkg::OP_ADD;
        else if (w[15:12] == iod_pkg::BSET_PREFIX)
            return iod_pkg::OP_BSET;
        else if (w[15:9] == iod_pkg::FILL_PREFIX)
            return iod_pkg::OP_FILL;
        else
            return iod_pkg::OP_NONE;
    endfunction : classify

    logic [7:0] f;
    logic acc_sel;

    assign f = dif.word[iod_pkg::OFFSET_LSB +: 8];
    assign acc_sel = dif.word[iod_pkg::ACCESS_BIT];
    assign dif.op = classify(dif.word);
    assign dif.dest_f = dif.word[iod_pkg::DEST_BIT];
    assign dif.bitpos = dif.word[iod_pkg::BITPOS_LSB +: 3];
    // Offset form only with the extension on, access bank chosen and a small operand
    assign dif.indexed = dif.ext_en && !acc_sel && (f <= iod_pkg::IDX_MAX_OFFSET);

    always_comb
    begin
        if (dif.indexed)
            dif.eff_addr = dif.frame_ptr + {4'h0, f};
        else if (acc_sel)
            dif.eff_addr = {dif.bank, f};
        else if (f < iod_pkg::ACCESS_SPLIT)
            dif.eff_addr = {iod_pkg::ACCESS_LO_BANK, f};
        else
            dif.eff_addr = {iod_pkg::ACCESS_HI_BANK, f};
    end

    ////////////////////////////////////////////////////////////////////////////
    low_access_a: assert property (@(posedge dif.clk) disable iff (dif.rst)
        (dif.ext_en && !dif.word[iod_pkg::ACCESS_BIT] && dif.word[7:0] <= iod_pkg::IDX_MAX_OFFSET) |->
        dif.indexed)
        else $error("small access operand not taken as offset");
    idx_gate_a: assert property (@(posedge dif.clk) disable iff (dif.rst)
        dif.indexed |-> (dif.ext_en && !dif.word[iod_pkg::ACCESS_BIT] && dif.word[7:0] <= iod_pkg::IDX_MAX_OFFSET))
        else $error("indexed form outside its conditions");
endmodule : iod_decode

//--- hw/iod_core.sv
// Execute core for indexed add, indexed bit set and indexed fill.
// Assumes an external data memory with a same-cycle read port and a write strobe.
// Function
// - Extension on: access operand up to 5Fh is an offset from the frame pointer.
// - Indexed add sums accumulator and byte at frame pointer plus offset 0..95.
// - Add destination bit 0 writes accumulator, 1 writes memory location.
// - Indexed add updates negative, overflow, carry, digit carry and zero.
// - Indexed add is opcode 0010 01d0 with an 8-bit offset.
// - One word, one cycle: decode Q1, offset Q2, process Q3, write Q4.
// - Indexed bit set sets bit b of indexed byte, flags untouched.
// - Indexed bit set is opcode 1000 bbb0 with an 8-bit offset.
// - Indexed fill writes FFh to indexed byte, flags untouched.
// - Indexed fill is opcode 0110 1000 with offset, one word, one cycle.
// - Extension enable defaults to 0; the programmer must set it.
// - Offset form only when access bit is 0; else bank register chooses bank.
`timescale 1ns/1ps
module iod_core (
    // Clock, reset, enable
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    // Instruction and configuration
    input wire logic [15:0] INSTR_I,
    input wire logic INSTR_VALID_I,
    input wire logic EXT_ENABLE_I,
    input wire logic [11:0] FRAME_PTR_I,
    input wire logic [3:0] BANK_I,
    // Data memory
    input wire logic [7:0] DMEM_RDATA_I,
    output logic [11:0] DMEM_ADDR_O,
    output logic DMEM_RD_O,
    output logic [7:0] DMEM_WDATA_O,
    output logic DMEM_WE_O,
    // Core state
    output logic [7:0] ACC_O,
    output logic [4:0] STATUS_O,
    output logic EXT_MODE_O,
    output logic CYCLE_END_O
);
    iod_dec_if dif ();
    iod_decode u_decode (.dif(dif));

    iod_pkg::iod_phase_t q;
    logic [15:0] ir;
    logic cfg_taken;
    iod_pkg::iod_op_t op_r;
    logic dest_r;
    logic [2:0] bit_r;
    logic [4:0] flags_r;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] next_res;
    logic [4:0] next_flags;

    assign dif.word = ir;
    assign dif.ext_en = EXT_MODE_O;
    assign dif.frame_ptr = FRAME_PTR_I;
    assign dif.bank = BANK_I;
    assign dif.clk = CLK_I;
    assign dif.rst = RST_I;

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequencer
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            q <= iod_pkg::Q1;
        else if (CE_I)
        begin
            case (q)
                iod_pkg::Q1: q <= iod_pkg::Q2;
                iod_pkg::Q2: q <= iod_pkg::Q3;
                iod_pkg::Q3: q <= iod_pkg::Q4;
                iod_pkg::Q4: q <= iod_pkg::Q1;
                default: q <= iod_pkg::Q1;
            endcase
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            CYCLE_END_O <= 1'b0;
        else if (CE_I)
            CYCLE_END_O <= (q == iod_pkg::Q4);
    end

    // Configuration is taken once after reset so a mid-run change cannot flip addressing
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            EXT_MODE_O <= iod_pkg::EXT_RESET;
            cfg_taken <= 1'b0;
        end
        else if (CE_I && !cfg_taken)
        begin
            EXT_MODE_O <= EXT_ENABLE_I;
            cfg_taken <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode: word latched in Q1, fields and address taken in Q2
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ir <= iod_pkg::NOP_WORD;
        else if (CE_I && q == iod_pkg::Q1)
            ir <= INSTR_VALID_I ? INSTR_I : iod_pkg::NOP_WORD;
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            op_r <= iod_pkg::OP_NONE;
            dest_r <= 1'b0;
            bit_r <= 3'h0;
            DMEM_ADDR_O <= 12'h000;
        end
        else if (CE_I && q == iod_pkg::Q2)
        begin
            op_r <= dif.op;
            dest_r <= dif.dest_f;
            bit_r <= dif.bitpos;
            DMEM_ADDR_O <= dif.eff_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Process in Q3
    always_comb
    begin
        sum = {1'b0, ACC_O} + {1'b0, DMEM_RDATA_I};
        nib = {1'b0, ACC_O[3:0]} + {1'b0, DMEM_RDATA_I[3:0]};
        next_flags = STATUS_O;
        next_res = DMEM_RDATA_I;
        case (op_r)
            iod_pkg::OP_ADD:
            begin
                next_res = sum[7:0];
                next_flags[iod_pkg::ST_C] = sum[8];
                next_flags[iod_pkg::ST_DC] = nib[4];
                next_flags[iod_pkg::ST_Z] = (sum[7:0] == 8'h00);
                next_flags[iod_pkg::ST_N] = sum[7];
                next_flags[iod_pkg::ST_OV] = (ACC_O[7] == DMEM_RDATA_I[7]) && (sum[7] != ACC_O[7]);
            end
            iod_pkg::OP_BSET: next_res = DMEM_RDATA_I | (8'h01 << bit_r);
            iod_pkg::OP_FILL: next_res = iod_pkg::FILL_VALUE;
            default: next_res = DMEM_RDATA_I;
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            DMEM_RD_O <= 1'b0;
        else if (CE_I)
            DMEM_RD_O <= (q == iod_pkg::Q2) && (dif.op != iod_pkg::OP_NONE);
    end

    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            DMEM_WDATA_O <= 8'h00;
            DMEM_WE_O <= 1'b0;
            flags_r <= iod_pkg::STATUS_RESET;
        end
        else if (CE_I && q == iod_pkg::Q3)
        begin
            DMEM_WDATA_O <= next_res;
            flags_r <= next_flags;
            // A sum bound for the accumulator never touches memory
            DMEM_WE_O <= (op_r != iod_pkg::OP_NONE) &&
                         !(op_r == iod_pkg::OP_ADD && dest_r == iod_pkg::DEST_ACC);
        end
        else if (CE_I)
            DMEM_WE_O <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write back in Q4; only the add touches accumulator and flags
    always_ff @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ACC_O <= iod_pkg::ACC_RESET;
            STATUS_O <= iod_pkg::STATUS_RESET;
        end
        else if (CE_I && q == iod_pkg::Q4 && op_r == iod_pkg::OP_ADD)
        begin
            STATUS_O <= flags_r;
            if (dest_r == iod_pkg::DEST_ACC)
                ACC_O <= DMEM_WDATA_O;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    phase_wrap_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (q == iod_pkg::Q4 && CE_I) |=> (q == iod_pkg::Q1))
        else $error("phase did not wrap to Q1");
    idx_addr_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (q == iod_pkg::Q2 && CE_I && dif.indexed) |=>
        (DMEM_ADDR_O == $past(FRAME_PTR_I) + {4'h0, $past(ir[7:0])}))
        else $error("indexed address wrong");
    bank_addr_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (q == iod_pkg::Q2 && CE_I && ir[iod_pkg::ACCESS_BIT]) |=>
        (DMEM_ADDR_O == {$past(BANK_I), $past(ir[7:0])}))
        else $error("banked address wrong");
    add_acc_dest_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (q == iod_pkg::Q4 && op_r == iod_pkg::OP_ADD && dest_r == iod_pkg::DEST_ACC) |-> !DMEM_WE_O)
        else $error("accumulator-bound add wrote memory");
    add_mem_dest_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (q == iod_pkg::Q3 && CE_I && op_r == iod_pkg::OP_ADD && dest_r) |=>
        (DMEM_WE_O && DMEM_WDATA_O == $past(ACC_O) + $past(DMEM_RDATA_I)))
        else $error("memory-bound add wrong");
    add_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (q == iod_pkg::Q4 && CE_I && op_r == iod_pkg::OP_ADD) |=>
        (STATUS_O[iod_pkg::ST_Z] == ($past(DMEM_WDATA_O) == 8'h00)))
        else $error("zero flag wrong");
    fill_value_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (DMEM_WE_O && op_r == iod_pkg::OP_FILL) |-> (DMEM_WDATA_O == iod_pkg::FILL_VALUE))
        else $error("fill value wrong");
    bset_bit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (q == iod_pkg::Q3 && CE_I && op_r == iod_pkg::OP_BSET) |=>
        (DMEM_WE_O && DMEM_WDATA_O[bit_r] && (DMEM_WDATA_O | (8'h01 << bit_r)) == ($past(DMEM_RDATA_I) | (8'h01 << bit_r))))
        else $error("bit set result wrong");
    flags_kept_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (op_r == iod_pkg::OP_BSET || op_r == iod_pkg::OP_FILL) |=> $stable(STATUS_O))
        else $error("flags changed by set or fill");
    add_decode_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        (ir[15:10] == iod_pkg::ADD_PREFIX |-> dif.op == iod_pkg::OP_ADD) and
        (ir[15:9] == iod_pkg::FILL_PREFIX |-> dif.op == iod_pkg::OP_FILL))
        else $error("opcode misdecoded");
    ext_default_a: assert property (@(posedge CLK_I) disable iff (RST_I)
        !EXT_MODE_O |-> !dif.indexed)
        else $error("offset form while extension off");
endmodule : iod_core

//--- bench/iod_tb.sv
// Self-checking bench for the indexed-offset execute core.
// Assumes a combinational data memory model and one instruction every eight clock cycles.
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end
module testbench;
    logic CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic CE_I = 1'b1;
    logic [15:0] INSTR_I = 16'h0000;
    logic INSTR_VALID_I = 1'b0;
    logic EXT_ENABLE_I = 1'b1;
    logic [11:0] FRAME_PTR_I = 12'h000;
    logic [3:0] BANK_I = 4'h0;
    logic [7:0] DMEM_RDATA_I;
    logic [11:0] DMEM_ADDR_O;
    logic DMEM_RD_O;
    logic [7:0] DMEM_WDATA_O;
    logic DMEM_WE_O;
    logic [7:0] ACC_O;
    logic [4:0] STATUS_O;
    logic EXT_MODE_O;
    logic CYCLE_END_O;
    logic [7:0] mem [0:4095];
    int wr_count = 0;
    int mismatches = 0;
    int samples_checked = 0;
    logic [4:0] st;

    always #5 CLK_I = ~CLK_I;

    iod_core u_iod_core (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .INSTR_I(INSTR_I),
        .INSTR_VALID_I(INSTR_VALID_I), .EXT_ENABLE_I(EXT_ENABLE_I), .FRAME_PTR_I(FRAME_PTR_I),
        .BANK_I(BANK_I), .DMEM_RDATA_I(DMEM_RDATA_I), .DMEM_ADDR_O(DMEM_ADDR_O), .DMEM_RD_O(DMEM_RD_O),
        .DMEM_WDATA_O(DMEM_WDATA_O), .DMEM_WE_O(DMEM_WE_O), .ACC_O(ACC_O), .STATUS_O(STATUS_O),
        .EXT_MODE_O(EXT_MODE_O), .CYCLE_END_O(CYCLE_END_O));

    ////////////////////////////////////////////////////////////////////////////////
    // Same-cycle read port; writes land on the edge that sees the strobe
    assign DMEM_RDATA_I = mem[DMEM_ADDR_O];
    always @(posedge CLK_I)
    begin
        if (DMEM_WE_O === 1'b1)
        begin
            mem[DMEM_ADDR_O] <= DMEM_WDATA_O;
            wr_count <= wr_count + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [4:0] add_flags(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] f;
        s = {1'b0, a} + {1'b0, b};
        f = 5'h00;
        f[iod_pkg::ST_C] = s[8];
        f[iod_pkg::ST_DC] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        f[iod_pkg::ST_Z] = (s[7:0] == 8'h00);
        f[iod_pkg::ST_OV] = (a[7] == b[7]) && (s[7] != a[7]);
        f[iod_pkg::ST_N] = s[7];
        return f;
    endfunction : add_flags

    task automatic do_reset(input logic ext);
        @(negedge CLK_I);
        RST_I = 1'b1;
        EXT_ENABLE_I = ext;
        INSTR_VALID_I = 1'b0;
        repeat (3) @(negedge CLK_I);
        `CHECK("acc in reset", 8'h00, ACC_O)
        `CHECK("write strobe in reset", 1'b0, DMEM_WE_O)
        RST_I = 1'b0;
        // First edge after release is a Q1 with no valid word
        repeat (3) @(negedge CLK_I);
        `CHECK("extension mode", ext, EXT_MODE_O)
    endtask : do_reset

    // Issues one word at a Q1 edge, then lets it and one idle slot run out
    task automatic exec(input logic [15:0] word, input logic [11:0] fp, input logic [3:0] bank);
        @(negedge CLK_I);
        wr_count = 0;
        INSTR_I = word;
        INSTR_VALID_I = 1'b1;
        FRAME_PTR_I = fp;
        BANK_I = bank;
        @(negedge CLK_I);
        INSTR_VALID_I = 1'b0;
        INSTR_I = 16'h0000;
        @(negedge CLK_I);
        `CHECK("read strobe", 1'b1, DMEM_RD_O)
        @(negedge CLK_I);
        `CHECK("early cycle end", 1'b0, CYCLE_END_O)
        @(negedge CLK_I);
        `CHECK("cycle end", 1'b1, CYCLE_END_O)
        repeat (2) @(negedge CLK_I);
        `CHECK("idle read strobe", 1'b0, DMEM_RD_O)
        @(negedge CLK_I);
    endtask : exec

    task automatic fill_at(input logic [15:0] word, input logic [11:0] fp, input logic [3:0] bank,
                           input logic [11:0] addr);
        mem[addr] = 8'h00;
        st = STATUS_O;
        exec(word, fp, bank);
        `CHECK("filled byte", 8'hff, mem[addr])
        `CHECK("fill writes", 1, wr_count)
        `CHECK("fill status", st, STATUS_O)
    endtask : fill_at

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_add_acc();
        mem[12'ha05] = 8'h17;
        exec({6'h09, 1'b0, 1'b0, 8'h05}, 12'ha00, 4'h0);
        `CHECK("acc load", 8'h17, ACC_O)
        mem[12'ha2c] = 8'h20;
        exec({6'h09, 1'b0, 1'b0, 8'h2c}, 12'ha00, 4'h0);
        `CHECK("acc sum", 8'h37, ACC_O)
        `CHECK("add to acc flags", add_flags(8'h17, 8'h20), STATUS_O)
        `CHECK("add to acc writes", 0, wr_count)
        `CHECK("source byte", 8'h20, mem[12'ha2c])
    endtask : test_add_acc

    task automatic test_add_mem();
        // Top offset with a pointer near the end wraps to the bottom of data space
        mem[12'h04f] = 8'hc9;
        exec({6'h09, 1'b1, 1'b0, 8'h5f}, 12'hff0, 4'h0);
        `CHECK("sum in memory", 8'h00, mem[12'h04f])
        `CHECK("acc kept", 8'h37, ACC_O)
        `CHECK("carry zero flags", add_flags(8'h37, 8'hc9), STATUS_O)
        `CHECK("add to memory writes", 1, wr_count)
    endtask : test_add_mem

    task automatic test_bit_set();
        for (int b = 0; b < 8; b++)
        begin
            mem[12'h100 + b] = 8'h55;
            st = STATUS_O;
            exec({4'h8, b[2:0], 1'b0, 8'(b)}, 12'h100, 4'h0);
            `CHECK("bit set byte", 8'h55 | (8'h01 << b), mem[12'h100 + b])
            `CHECK("bit set status", st, STATUS_O)
        end
    endtask : test_bit_set

    task automatic test_fill();
        fill_at({8'h68, 8'h00}, 12'ha00, 4'h0, 12'ha00);
        fill_at({8'h68, 8'h5f}, 12'ha00, 4'h0, 12'ha5f);
        // Above the offset range the operand is an absolute access-bank address
        fill_at({8'h68, 8'h60}, 12'ha00, 4'h0, 12'h060);
        fill_at({8'h69, 8'h10}, 12'ha00, 4'h3, 12'h310);
    endtask : test_fill

    // Clock enable dropped in Q3 must hold the fill until it comes back
    task automatic test_stall();
        mem[12'ha33] = 8'h00;
        @(negedge CLK_I);
        INSTR_I = {8'h68, 8'h33};
        INSTR_VALID_I = 1'b1;
        FRAME_PTR_I = 12'ha00;
        BANK_I = 4'h0;
        @(negedge CLK_I);
        INSTR_VALID_I = 1'b0;
        INSTR_I = 16'h0000;
        @(negedge CLK_I);
        CE_I = 1'b0;
        repeat (4) @(negedge CLK_I);
        `CHECK("frozen read strobe", 1'b1, DMEM_RD_O)
        `CHECK("frozen address", 12'ha33, DMEM_ADDR_O)
        `CHECK("frozen byte", 8'h00, mem[12'ha33])
        CE_I = 1'b1;
        repeat (5) @(negedge CLK_I);
        `CHECK("byte after freeze", 8'hff, mem[12'ha33])
    endtask : test_stall

    task automatic test_ext_off();
        do_reset(1'b0);
        fill_at({8'h68, 8'h10}, 12'ha00, 4'h0, 12'h010);
    endtask : test_ext_off

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        #50000;
        mismatches++;
        give_verdict();
    end

    initial
    begin
        do_reset(1'b1);
        test_add_acc();
        test_add_mem();
        test_bit_set();
        test_fill();
        test_stall();
        test_ext_off();
        give_verdict();
    end
endmodule : testbench
